// *** verilog/els_pkg.sv ***
// Constants shared by the line status and event register group
package els_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [6:0] IDX_CNT_CTRL = 7'h31;
  localparam logic [6:0] IDX_ENABLE0 = 7'h33;
  localparam logic [6:0] IDX_ENABLE1 = 7'h34;
  localparam logic [6:0] IDX_EDGE_SEL = 7'h35;
  localparam logic [6:0] IDX_LIVE = 7'h36;
  localparam logic [6:0] IDX_GAIN = 7'h37;
  localparam logic [6:0] IDX_TX_JITTER = 7'h38;
  localparam logic [6:0] IDX_RX_JITTER = 7'h39;
  localparam logic [6:0] IDX_EVENT0 = 7'h3a;
  localparam logic [6:0] IDX_EVENT1 = 7'h3b;
  localparam logic [6:0] IDX_COUNT_HIGH = 7'h3c;
  localparam logic [6:0] IDX_COUNT_LOW = 7'h3d;
  localparam logic [6:0] IDX_REF_CTRL = 7'h3e;
  localparam logic [6:0] IDX_LINE_SUM = 7'h3f;
  localparam logic [6:0] IDX_FRAME_SUM = 7'h40;
  localparam logic [6:0] IDX_JITTER_SEL = 7'h50;
  // ----------------------------------------
  // Field positions and writable masks
  // ----------------------------------------
  localparam int B_DRIVER = 2;
  localparam int B_LOSS = 0;
  localparam int B_TEMPLATE = 6;
  localparam int B_TX_FIFO = 5;
  localparam int B_RX_FIFO = 4;
  localparam int B_ZERO = 2;
  localparam int B_VIOL = 1;
  localparam int B_CNT_OVF = 0;
  localparam logic [7:0] MASK_EVENT0 = 8'h05;
  localparam logic [7:0] MASK_EVENT1 = 8'h77;
  localparam logic [7:0] MASK_CNT_CTRL = 8'h1f;
  localparam logic [7:0] MASK_JITTER_SEL = 8'h03;
  localparam logic [7:0] MASK_REF_CTRL = 8'h01;
  localparam logic [7:0] MASK_JITTER_CLR = 8'h7f;
  localparam int B_TRANSFER = 0;
  localparam int B_AUTO = 1;
  localparam int B_COUNT_LO = 2;
  localparam logic [1:0] COUNT_ON = 2'h1;
  localparam int B_HOLD_HIGH = 0;
  localparam int B_LINE_SUM = 0;
  localparam int B_ALARM = 5;
  localparam int B_PERF = 4;
  localparam int B_PATTERN = 3;
  localparam int B_SIGNALING = 2;
  localparam int B_FRAME_GEN = 1;
  localparam int B_FRAME_PROC = 0;
  localparam int GAIN_W = 5;
  localparam int JITTER_W = 7;
  localparam int COUNT_W = 16;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int REPORT_PERIOD_NS = 1_000_000_000;
  localparam int REPORT_TICKS = REPORT_PERIOD_NS / CLK_PERIOD_NS;
endpackage : els_pkg

// *** verilog/els_jitter_if.sv ***
// Bundle between the register group and one jitter measure unit
`timescale 1ns/1ns
interface els_jitter_if #(parameter int W = 7);
  logic [W-1:0] spacing; // Live pointer spacing
  logic peakSel; // High: report peak-to-peak
  logic clear; // Host wrote a one
  logic readAck; // Host read completed
  logic [W-1:0] value; // Reported measure
  modport meas (input spacing, peakSel, clear, readAck, output value);
  modport ctl (output spacing, peakSel, clear, readAck, input value);
endinterface : els_jitter_if

// *** verilog/els_jitter_meas.sv ***
// One jitter FIFO pointer spacing measure, live or peak-to-peak
`timescale 1ns/1ns
module els_jitter_meas #(
  parameter int W = els_pkg::JITTER_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  els_jitter_if.meas jm
);
  if (W < 2) begin : gBadWidth
    $error("els_jitter_meas: W must be at least 2");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [W-1:0] value; // Reported figure
    logic [W-1:0] maxV; // Largest spacing in window
    logic [W-1:0] minV; // Smallest spacing in window
  } els_jit_state_t;

  els_jit_state_t s_q;
  els_jit_state_t s_d;

  // Window restarts on clear, on a read, or in live mode
  always_comb begin
    s_d = s_q;
    if (jm.clear || jm.readAck || !jm.peakSel) begin
      s_d.maxV = jm.spacing;
      s_d.minV = jm.spacing;
    end else begin
      if (jm.spacing > s_q.maxV) begin
        s_d.maxV = jm.spacing;
      end
      if (jm.spacing < s_q.minV) begin
        s_d.minV = jm.spacing;
      end
    end
    if (jm.clear) begin
      s_d.value = '0; // R4
    end else if (!jm.peakSel) begin
      s_d.value = jm.spacing; // R2
    end else begin
      s_d.value = s_d.maxV - s_d.minV; // R3
    end
  end

  // Registered state, frozen while ce is low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign jm.value = s_q.value;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_JIT_CLEAR: assert property (@(posedge sys_clk) disable iff (reset) // R4
    ce && jm.clear |=> jm.value == '0)
    else $error("jitter measure not cleared by host write");
  AST_JIT_LIVE: assert property (@(posedge sys_clk) disable iff (reset) // R2
    ce && !jm.clear && !jm.peakSel |=> jm.value == $past(jm.spacing))
    else $error("live jitter measure does not follow spacing");
  AST_JIT_PEAK: assert property (@(posedge sys_clk) disable iff (reset) // R3
    ce && jm.peakSel && !jm.clear && !jm.readAck && $past(ce) && $past(jm.peakSel)
    |=> jm.value >= $past(jm.value))
    else $error("peak-to-peak measure shrank without a read");
endmodule : els_jitter_meas

// *** verilog/els_line_status.sv ***
// Line status, measurement and event flag registers on classic Wishbone
//
// How it works
// R1: Gain code reported read-only, five bits
// R2: Transmit measure: live or peak spacing
// R3: Receive measure: live or peak spacing
// R4: Writing one clears jitter measure value
// R5: Fault and loss flags: rising or both
// R6: Template overflow strobe sets its flag
// R7: Transmit FIFO over/underflow sets flag
// R8: Receive FIFO over/underflow sets flag
// R9: Excess zero error sets its flag
// R10: Bipolar or code violation sets flag
// R11: Zero counter wrap sets overflow flag
// R12: Flags sticky until host writes one
// R13: Count high byte low address
// R14: Loss with hold bit: reference pin high
// R15: Line summary shows any enabled pending line flag
// R16: Framing summary bits three down to zero
// R17: Performance monitor summary at bit four
// R18: Alarm detector summary bit follows block
// R19: Enable bit gates each flag to pin
// R20: Edge select one: any change sets
// R21: Count copied on transfer edge or second
// R22: Simultaneous set and clear keeps flag set
// R23: Reserved bits read zero, writes ignored
`timescale 1ns/1ns
module els_line_status #(
  parameter int ADR_W = 9,
  parameter int REPORT_TICKS = els_pkg::REPORT_TICKS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [ADR_W-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic [els_pkg::GAIN_W-1:0] rxGainCode,
  input wire logic [els_pkg::JITTER_W-1:0] txPointerSpacing,
  input wire logic [els_pkg::JITTER_W-1:0] rxPointerSpacing,
  input wire logic driverFaultLive,
  input wire logic signalLossLive,
  input wire logic templateOverflow,
  input wire logic txAttenuatorFifoErr,
  input wire logic rxAttenuatorFifoErr,
  input wire logic excessZeroError,
  input wire logic bipolarViolation,
  input wire logic lineCodeViolation,
  input wire logic alarmIrq,
  input wire logic perfMonitorIrq,
  input wire logic patternGenDetectIrq,
  input wire logic rxSignalingBufferIrq,
  input wire logic frameGeneratorIrq,
  input wire logic frameProcessorIrq,
  input wire logic masterClock,
  output logic referenceClockPin,
  output logic lineIntN
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ADR_W < 9) begin : gBadAdr
    $error("els_line_status: ADR_W must reach word index 0x50");
  end
  if (REPORT_TICKS < 2) begin : gBadTicks
    $error("els_line_status: REPORT_TICKS must be at least 2");
  end

  localparam int SEC_W = $clog2(REPORT_TICKS);
  localparam int CW = els_pkg::COUNT_W;
  localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(REPORT_TICKS - 1);
  localparam logic [CW-1:0] COUNT_FULL = '1;

  // ----------------------------------------
  // State of the group, apart from the jitter measure units
  // ----------------------------------------
  typedef struct packed {
    logic ack; // Bus answer, one cycle
    logic [7:0] rdat; // Read data for the answer
    logic [7:0] evt0; // Fault and loss flags
    logic [7:0] evt1; // Line error flags
    logic [7:0] en0; // Enables for evt0
    logic [7:0] en1; // Enables for evt1
    logic [7:0] edgeSel; // Edge selects for evt0
    logic [7:0] cntCtrl; // Counter mode and transfer
    logic [7:0] jitSel; // Peak measure selects
    logic [7:0] refCtrl; // Reference pin control
    logic dfPrev; // Last driver fault level
    logic losPrev; // Last loss level
    logic trfPrev; // Last transfer bit
    logic [CW-1:0] cnt; // Internal zero run counter
    logic [CW-1:0] hold; // Counter snapshot for reading
    logic [SEC_W-1:0] sec; // One second divider
    logic intN; // Interrupt pin, active low
  } els_state_t;

  els_state_t s_q;
  els_state_t s_d;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [6:0] idx; // Word index
  logic request; // Master presents a cycle
  logic accept; // Edge at which the master samples ack
  logic wr; // Write that takes effect now
  logic rd; // Read completed now
  logic [7:0] wByte; // Low byte of write data

  assign idx = wbAdr[8:2];
  assign request = wbCyc && wbStb;
  assign accept = request && s_q.ack;
  // Only lane 0 carries data; a write without it changes nothing
  assign wr = accept && wbWe && wbSel[0];
  assign rd = accept && !wbWe;
  assign wByte = wbDatW[7:0];

  // ----------------------------------------
  // Jitter measures, one unit per direction
  // ----------------------------------------
  els_jitter_if #(.W(els_pkg::JITTER_W)) jit[2] ();
  logic [1:0][els_pkg::JITTER_W-1:0] spacingIn;
  logic [1:0][els_pkg::JITTER_W-1:0] jitValue;

  assign spacingIn = {rxPointerSpacing, txPointerSpacing};

  for (genvar ch = 0; ch < 2; ch++) begin : gJit
    localparam logic [6:0] MY_IDX = els_pkg::IDX_TX_JITTER + 7'(ch);
    assign jit[ch].spacing = spacingIn[ch];
    assign jit[ch].peakSel = s_q.jitSel[ch]; // R2 R3
    // Any one written into the value field clears it
    assign jit[ch].clear = wr && idx == MY_IDX && |(wByte & els_pkg::MASK_JITTER_CLR); // R4
    assign jit[ch].readAck = rd && idx == MY_IDX;
    assign jitValue[ch] = jit[ch].value;
    els_jitter_meas #(.W(els_pkg::JITTER_W)) uMeas (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .jm(jit[ch])
    );
  end

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  logic dfSet; // Driver fault change seen
  logic losSet; // Loss change seen
  logic countOn; // Counting enabled
  logic zeroInc; // Counter steps this cycle
  logic autoMode; // Snapshot once per second
  logic secTick; // Second boundary
  logic transfer; // Snapshot now
  logic [7:0] set0; // New events for evt0
  logic [7:0] set1; // New events for evt1
  logic [7:0] clr0; // Host clears for evt0
  logic [7:0] clr1; // Host clears for evt1
  logic lineSum; // Any enabled line flag pending
  logic [7:0] frameSum; // Framing block summary byte

  // Rising edge, or either edge when its select is set
  always_comb begin
    dfSet = driverFaultLive && !s_q.dfPrev; // R5
    losSet = signalLossLive && !s_q.losPrev; // R5
    if (s_q.edgeSel[els_pkg::B_DRIVER]) begin
      dfSet = driverFaultLive != s_q.dfPrev; // R20
    end
    if (s_q.edgeSel[els_pkg::B_LOSS]) begin
      losSet = signalLossLive != s_q.losPrev; // R20
    end
  end

  assign countOn = s_q.cntCtrl[els_pkg::B_COUNT_LO +: 2] == els_pkg::COUNT_ON;
  assign zeroInc = countOn && excessZeroError;
  assign autoMode = s_q.cntCtrl[els_pkg::B_AUTO];
  assign secTick = autoMode && s_q.sec == SEC_LAST;
  // Manual mode snapshots only on a 0 to 1 change of the transfer bit
  assign transfer = autoMode ? secTick
                             : s_q.cntCtrl[els_pkg::B_TRANSFER] && !s_q.trfPrev; // R21

  // Gather the event strobes into flag positions
  always_comb begin
    set0 = els_pkg::RESET_BYTE;
    set1 = els_pkg::RESET_BYTE;
    set0[els_pkg::B_DRIVER] = dfSet; // R5
    set0[els_pkg::B_LOSS] = losSet; // R5
    set1[els_pkg::B_TEMPLATE] = templateOverflow; // R6
    set1[els_pkg::B_TX_FIFO] = txAttenuatorFifoErr; // R7
    set1[els_pkg::B_RX_FIFO] = rxAttenuatorFifoErr; // R8
    set1[els_pkg::B_ZERO] = excessZeroError; // R9
    set1[els_pkg::B_VIOL] = bipolarViolation || lineCodeViolation; // R10
    set1[els_pkg::B_CNT_OVF] = zeroInc && s_q.cnt == COUNT_FULL; // R11
  end

  // Write-one-to-clear, reserved positions masked out
  assign clr0 = (wr && idx == els_pkg::IDX_EVENT0) ? wByte & els_pkg::MASK_EVENT0 : '0; // R12
  assign clr1 = (wr && idx == els_pkg::IDX_EVENT1) ? wByte & els_pkg::MASK_EVENT1 : '0; // R12

  // Summary of the line flags that are allowed onto the pin
  assign lineSum = |(s_q.evt0 & s_q.en0 & els_pkg::MASK_EVENT0)
                || |(s_q.evt1 & s_q.en1 & els_pkg::MASK_EVENT1); // R15 R19

  always_comb begin
    frameSum = els_pkg::RESET_BYTE;
    frameSum[els_pkg::B_ALARM] = alarmIrq; // R18
    frameSum[els_pkg::B_PERF] = perfMonitorIrq; // R17
    frameSum[els_pkg::B_PATTERN] = patternGenDetectIrq; // R16
    frameSum[els_pkg::B_SIGNALING] = rxSignalingBufferIrq; // R16
    frameSum[els_pkg::B_FRAME_GEN] = frameGeneratorIrq; // R16
    frameSum[els_pkg::B_FRAME_PROC] = frameProcessorIrq; // R16
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  logic [7:0] rMux; // Byte for the addressed register

  // Unmapped indices read zero; reserved bits are zero by construction
  always_comb begin
    rMux = els_pkg::RESET_BYTE;
    case (idx)
      els_pkg::IDX_CNT_CTRL: rMux = s_q.cntCtrl;
      els_pkg::IDX_ENABLE0: rMux = s_q.en0;
      els_pkg::IDX_ENABLE1: rMux = s_q.en1;
      els_pkg::IDX_EDGE_SEL: rMux = s_q.edgeSel;
      els_pkg::IDX_LIVE: begin
        rMux[els_pkg::B_DRIVER] = driverFaultLive;
        rMux[els_pkg::B_LOSS] = signalLossLive;
      end
      els_pkg::IDX_GAIN: rMux = 8'(rxGainCode); // R1
      els_pkg::IDX_TX_JITTER: rMux = 8'(jitValue[0]); // R2
      els_pkg::IDX_RX_JITTER: rMux = 8'(jitValue[1]); // R3
      els_pkg::IDX_EVENT0: rMux = s_q.evt0;
      els_pkg::IDX_EVENT1: rMux = s_q.evt1;
      els_pkg::IDX_COUNT_HIGH: rMux = s_q.hold[15:8]; // R13
      els_pkg::IDX_COUNT_LOW: rMux = s_q.hold[7:0]; // R13
      els_pkg::IDX_REF_CTRL: rMux = s_q.refCtrl;
      els_pkg::IDX_LINE_SUM: rMux[els_pkg::B_LINE_SUM] = lineSum; // R15
      els_pkg::IDX_FRAME_SUM: rMux = frameSum; // R16
      els_pkg::IDX_JITTER_SEL: rMux = s_q.jitSel;
      default: rMux = els_pkg::RESET_BYTE; // R23
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // Answer one cycle after the request; drop it the cycle after
    s_d.ack = request && !s_q.ack;
    if (request && !s_q.ack) begin
      s_d.rdat = rMux;
    end
    // Set after clear, so an event in the clearing cycle survives
    s_d.evt0 = (s_q.evt0 & ~clr0) | set0; // R12 R22
    s_d.evt1 = (s_q.evt1 & ~clr1) | set1; // R12 R22
    s_d.dfPrev = driverFaultLive;
    s_d.losPrev = signalLossLive;
    s_d.trfPrev = s_q.cntCtrl[els_pkg::B_TRANSFER];
    // Divider runs only in automatic mode, so manual mode has no stale phase
    if (!autoMode || secTick) begin
      s_d.sec = '0;
    end else begin
      s_d.sec = s_q.sec + SEC_W'(1);
    end
    // Snapshot restarts the counter; an event in that cycle is kept
    if (transfer) begin
      s_d.hold = s_q.cnt; // R21
      s_d.cnt = CW'(zeroInc);
    end else if (zeroInc) begin
      s_d.cnt = s_q.cnt + CW'(1); // R11
    end
    // Control writes; reserved bits stay zero
    if (wr) begin
      case (idx)
        els_pkg::IDX_CNT_CTRL: s_d.cntCtrl = wByte & els_pkg::MASK_CNT_CTRL; // R23
        els_pkg::IDX_ENABLE0: s_d.en0 = wByte & els_pkg::MASK_EVENT0; // R23
        els_pkg::IDX_ENABLE1: s_d.en1 = wByte & els_pkg::MASK_EVENT1; // R23
        els_pkg::IDX_EDGE_SEL: s_d.edgeSel = wByte & els_pkg::MASK_EVENT0; // R23
        els_pkg::IDX_REF_CTRL: s_d.refCtrl = wByte & els_pkg::MASK_REF_CTRL; // R23
        els_pkg::IDX_JITTER_SEL: s_d.jitSel = wByte & els_pkg::MASK_JITTER_SEL; // R23
        default: s_d.cntCtrl = s_q.cntCtrl;
      endcase
    end
    // Pin drops one cycle after an enabled flag is seen
    s_d.intN = !lineSum; // R19
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.intN <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wbAck = s_q.ack;
  assign wbDatR = {24'h000000, s_q.rdat};
  assign lineIntN = s_q.intN;
  // Clock mux by level; the hold bit is meant to change only outside loss
  assign referenceClockPin = (signalLossLive && s_q.refCtrl[els_pkg::B_HOLD_HIGH])
                           ? 1'b1 : masterClock; // R14

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence seqManualRise;
    ce && !s_q.cntCtrl[els_pkg::B_AUTO] && s_q.cntCtrl[els_pkg::B_TRANSFER] && !s_q.trfPrev;
  endsequence

  sequence seqClearWithEvent;
    ce && wr && idx == els_pkg::IDX_EVENT1 && wByte[els_pkg::B_VIOL] && bipolarViolation;
  endsequence

  AST_BUS_ACK_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
    ce && request && !wbAck |=> wbAck ##1 (!ce || !wbAck))
    else $error("bus answer not a single cycle after request");
  AST_FAULT_RISE: assert property (@(posedge sys_clk) disable iff (reset) // R5
    ce && driverFaultLive && !s_q.dfPrev |=> s_q.evt0[els_pkg::B_DRIVER])
    else $error("driver fault rise did not set its flag");
  AST_LOSS_ANY: assert property (@(posedge sys_clk) disable iff (reset) // R20
    ce && s_q.edgeSel[els_pkg::B_LOSS] && signalLossLive != s_q.losPrev
    |=> s_q.evt0[els_pkg::B_LOSS])
    else $error("loss change with edge select did not set flag");
  AST_LOSS_FALL_QUIET: assert property (@(posedge sys_clk) disable iff (reset) // R5
    ce && !s_q.edgeSel[els_pkg::B_LOSS] && !s_q.evt0[els_pkg::B_LOSS]
    && !signalLossLive |=> !s_q.evt0[els_pkg::B_LOSS])
    else $error("loss flag set without a rising change");
  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (reset) // R22
    seqClearWithEvent |=> s_q.evt1[els_pkg::B_VIOL])
    else $error("event lost against a host clear");
  AST_STICKY: assert property (@(posedge sys_clk) disable iff (reset) // R12
    ce && s_q.evt1[els_pkg::B_ZERO] && !clr1[els_pkg::B_ZERO]
    |=> s_q.evt1[els_pkg::B_ZERO])
    else $error("zero run flag fell without a host clear");
  AST_MANUAL_XFER: assert property (@(posedge sys_clk) disable iff (reset) // R21
    seqManualRise |=> s_q.hold == $past(s_q.cnt))
    else $error("manual transfer did not copy the counter");
  AST_COUNT_WRAP: assert property (@(posedge sys_clk) disable iff (reset) // R11
    ce && zeroInc && s_q.cnt == COUNT_FULL && !transfer
    |=> s_q.evt1[els_pkg::B_CNT_OVF] && s_q.cnt == '0)
    else $error("counter wrap did not raise overflow flag");
  AST_INT_QUIET: assert property (@(posedge sys_clk) disable iff (reset) // R19
    ce && !lineSum |=> lineIntN)
    else $error("interrupt pin low with no enabled flag");
  AST_INT_ACTIVE: assert property (@(posedge sys_clk) disable iff (reset) // R19
    ce && lineSum |=> !lineIntN)
    else $error("enabled flag did not pull the interrupt pin");
  AST_REF_HOLD: assert property (@(posedge sys_clk) disable iff (reset) // R14
    signalLossLive && s_q.refCtrl[els_pkg::B_HOLD_HIGH] |-> referenceClockPin)
    else $error("reference pin not held high during loss");
  AST_RESERVED: assert property (@(posedge sys_clk) disable iff (reset) // R23
    (s_q.evt0 & ~els_pkg::MASK_EVENT0) == '0 && (s_q.evt1 & ~els_pkg::MASK_EVENT1) == '0)
    else $error("reserved flag bit became set");
endmodule : els_line_status

// *** verif/tb.sv ***
// Self-checking bench for the line status, measurement and event register group
`timescale 1ns/1ns
module tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic sys_clk = 1'b0; // 100 MHz system clock
  logic reset = 1'b1; // Synchronous reset, active high
  logic masterClock = 1'b0; // Unrelated clock that the reference pin may carry
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [8:0] wbAdr = 9'h000;
  logic [31:0] wbDatW = 32'h0;
  logic [4:0] gain = 5'h00; // Receive gain code
  logic [6:0] txSp = 7'h00, rxSp = 7'h00; // Pointer spacings
  logic faultLive = 1'b0, lossLive = 1'b0; // Live status levels
  logic [5:0] ev = 6'h00; // Event strobes, template in bit 0
  logic [5:0] irq = 6'h00; // Block summaries, alarm in bit 5
  logic [31:0] wbDatR;
  logic wbAck, referenceClockPin, lineIntN;
  int mismatches = 0, check_count = 0;
  // Flag bit that each strobe of ev sets; both violation kinds share one flag
  logic [7:0] evBit [0:5] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h02};
  always #5 sys_clk = ~sys_clk;
  always #7 masterClock = ~masterClock;
  // ----------------------------------------
  // Device under test, short report period
  // ----------------------------------------
  els_line_status #(.ADR_W(9), .REPORT_TICKS(20)) u_dut (.sys_clk(sys_clk), .reset(reset),
    .ce(1'b1), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'h1),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .rxGainCode(gain),
    .txPointerSpacing(txSp), .rxPointerSpacing(rxSp), .driverFaultLive(faultLive),
    .signalLossLive(lossLive), .templateOverflow(ev[0]), .txAttenuatorFifoErr(ev[1]),
    .rxAttenuatorFifoErr(ev[2]), .excessZeroError(ev[3]), .bipolarViolation(ev[4]),
    .lineCodeViolation(ev[5]), .alarmIrq(irq[5]), .perfMonitorIrq(irq[4]),
    .patternGenDetectIrq(irq[3]), .rxSignalingBufferIrq(irq[2]),
    .frameGeneratorIrq(irq[1]), .frameProcessorIrq(irq[0]), .masterClock(masterClock),
    .referenceClockPin(referenceClockPin), .lineIntN(lineIntN));
  // ----------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk
  // One classic cycle; the request stands until the rising edge that samples ack
  // high, read data is taken at that edge, and only then is the request released
  task automatic bus(input logic we, input logic [6:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbDatW <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 20) begin
        mismatches++;
        close_out();
      end
    end while (wbAck !== 1'b1);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, {24'h0, exp});
  endtask : rd
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic [6:0] jIdx [0:1];
    jIdx = '{els_pkg::IDX_TX_JITTER, els_pkg::IDX_RX_JITTER};
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    // Registers 0x37 to 0x40 read zero after reset, unmapped place too
    for (int i = 'h37; i <= 'h40; i++) rd(i[6:0], 8'h00);
    rd(7'h60, 8'h00);
    // Gain code passes through, top codes unchanged, writes ignored
    gain <= 5'h15;
    rd(els_pkg::IDX_GAIN, 8'h15);
    gain <= 5'h1f;
    wr(els_pkg::IDX_GAIN, 8'hff);
    rd(els_pkg::IDX_GAIN, 8'h1f);
    // Fault on rising edge only with select 0
    faultLive <= 1'b1;
    rd(els_pkg::IDX_EVENT0, 8'h04);
    wr(els_pkg::IDX_EVENT0, 8'h04);
    faultLive <= 1'b0;
    rd(els_pkg::IDX_EVENT0, 8'h00);
    // Select 1: loss sets on both edges; hold bit drives the pin high
    wr(els_pkg::IDX_EDGE_SEL, 8'h05);
    lossLive <= 1'b1;
    rd(els_pkg::IDX_EVENT0, 8'h01);
    wr(els_pkg::IDX_REF_CTRL, 8'hff);
    rd(els_pkg::IDX_REF_CTRL, 8'h01);
    @(negedge masterClock);
    #1 chk(referenceClockPin, 1'b1);
    wr(els_pkg::IDX_REF_CTRL, 8'h00);
    @(negedge masterClock);
    #1 chk(referenceClockPin, 1'b0);
    wr(els_pkg::IDX_EVENT0, 8'h01);
    lossLive <= 1'b0;
    rd(els_pkg::IDX_EVENT0, 8'h01);
    // Each strobe sets its flag, drives the pin, and one write clears it
    wr(els_pkg::IDX_ENABLE1, 8'h77);
    for (int i = 0; i < 6; i++) begin
      ev <= 6'h01 << i;
      @(posedge sys_clk);
      ev <= 6'h00;
      rd(els_pkg::IDX_EVENT1, evBit[i]);
      rd(els_pkg::IDX_LINE_SUM, 8'h01);
      @(negedge sys_clk) chk(lineIntN, 1'b0);
      wr(els_pkg::IDX_EVENT1, evBit[i]);
    end
    // Clearing one of two flags; disabled flag stays silent
    ev <= 6'h03;
    @(posedge sys_clk);
    ev <= 6'h00;
    wr(els_pkg::IDX_EVENT1, 8'h40);
    rd(els_pkg::IDX_EVENT1, 8'h20);
    wr(els_pkg::IDX_ENABLE1, 8'h00);
    rd(els_pkg::IDX_LINE_SUM, 8'h00);
    @(negedge sys_clk) chk(lineIntN, 1'b1);
    wr(els_pkg::IDX_EVENT1, 8'h20);
    // Violation held through a clearing write: the flag must survive it
    ev <= 6'h10;
    wr(els_pkg::IDX_EVENT1, 8'h02);
    ev <= 6'h00;
    rd(els_pkg::IDX_EVENT1, 8'h02);
    wr(els_pkg::IDX_EVENT1, 8'h02);
    // Block summaries read straight through
    irq <= 6'h2a;
    rd(els_pkg::IDX_FRAME_SUM, 8'h2a);
    irq <= 6'h15;
    rd(els_pkg::IDX_FRAME_SUM, 8'h15);
    // Manual transfer of three counted errors, high byte first
    wr(els_pkg::IDX_CNT_CTRL, 8'h04);
    ev <= 6'h08;
    repeat (3) @(posedge sys_clk);
    ev <= 6'h00;
    wr(els_pkg::IDX_CNT_CTRL, 8'h05);
    rd(els_pkg::IDX_COUNT_HIGH, 8'h00);
    rd(els_pkg::IDX_COUNT_LOW, 8'h03);
    // A full 16-bit run of errors wraps the counter
    ev <= 6'h08;
    repeat (65536) @(posedge sys_clk);
    ev <= 6'h00;
    rd(els_pkg::IDX_EVENT1, 8'h05);
    // Automatic mode copies two errors after one report period
    wr(els_pkg::IDX_CNT_CTRL, 8'h06);
    ev <= 6'h08;
    repeat (2) @(posedge sys_clk);
    ev <= 6'h00;
    repeat (22) @(posedge sys_clk);
    rd(els_pkg::IDX_COUNT_LOW, 8'h02);
    // Live spacing, then peak-to-peak since last read, then clear
    txSp <= 7'h2a;
    rxSp <= 7'h55;
    rd(els_pkg::IDX_TX_JITTER, 8'h2a);
    rd(els_pkg::IDX_RX_JITTER, 8'h55);
    txSp <= 7'h10;
    rxSp <= 7'h10;
    wr(els_pkg::IDX_JITTER_SEL, 8'h03);
    for (int u = 0; u < 2; u++) bus(1'b0, jIdx[u], 8'h00, q);
    txSp <= 7'h30;
    rxSp <= 7'h30;
    for (int u = 0; u < 2; u++) begin
      rd(jIdx[u], 8'h20);
      wr(jIdx[u], 8'h01);
      rd(jIdx[u], 8'h00);
    end
    close_out();
  end
endmodule : tb
